// File: hw/status_output_router_defines.svh
// register offsets, field positions, reset values for the status output router
// assumes a 32-bit AHB-Lite slave with one register per aligned word
`ifndef STATUS_OUTPUT_ROUTER_DEFINES_SVH
`define STATUS_OUTPUT_ROUTER_DEFINES_SVH

`define SEL_FIRST_OFS    12'h000
`define SEL_SECOND_OFS   12'h004
`define SEL_THIRD_OFS    12'h008
`define INV_CTRL_OFS     12'h00c
`define FLAG_STATE_OFS   12'h010
`define TERM_STATE_OFS   12'h014

`define SEL_FIRST_RST    16'h3211
`define SEL_SECOND_RST   16'h0000
`define SEL_THIRD_RST    16'h0000
`define INV_CTRL_RST     16'h0000

`define NUM_FLAGS        10
`define NUM_TERMS        3
`define DIGIT_W          4
`define SPEED_POSITIONING_COMPLETE_FLAG_IDX   1

`endif

// File: hw/status_output_router_pkg.sv
// types shared by the status output router
// assumes the defines header is compiled alongside
package status_output_router_pkg;

    // one register access request, read or write, captured in the address phase
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [11:0] addr;
    } bus_req_t;

    typedef enum logic [1:0] {
        TERM_NONE  = 2'b00,
        TERM_ONE   = 2'b01,
        TERM_TWO   = 2'b10,
        TERM_THREE = 2'b11
    } term_sel_t;

endpackage

// File: hw/status_output_router.sv
// status output router: ten status flags onto three output terminals
// assumes synchronous same-clock flags, except network_module_fitted, a pin
// assumes a single AHB-Lite master and hready tied to hreadyout
// What this block does
// - digit 0 none, 1-3 pick terminal
// - flags sharing a terminal are ORed
// - undetected flags never drive a terminal
// - speed-coincidence forced off with network module
// - invert digits 0-2 flip terminals one-three
// - first select resets 3211, others zero
// - fixed digit placement of the ten flags
// - invert register resets to zero
// - brake alone only if terminal unshared
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "status_output_router_defines.svh"
`default_nettype none

module status_output_router
    import status_output_router_pkg::*;
(
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic [`NUM_FLAGS-1:0] status_flags,
    input  wire logic [`NUM_FLAGS-1:0] flag_detected,
    input  wire logic                  network_module_fitted,
    output logic                       out_terminal_one,
    output logic                       out_terminal_two,
    output logic                       out_terminal_three
);

    // flag index order: positioning_complete, speed_coincidence, rotation_detect,
    // servo_ready, torque_limit, speed_limit, brake_interlock, warning,
    // near_position, index_phase
    // register map, one aligned word each, low half used:
    //   0x00 first select, 0x04 second select, 0x08 third select (low byte only)
    //   0x0c inversion, only bits 0, 4 and 8 are kept; digit three reads zero
    //   0x10 effective flags in bits 9:0, synchronised fitted pin in bit 10
    //   0x14 terminal state in bits 2:0
    // unmapped offsets ignore writes and read zero, never an error response
    // latency: a flag change shows on its terminal one clock later; a select
    // or invert write shows three clocks after its address phase
    logic [15:0]           sel_first_r, sel_first_nxt;
    logic [15:0]           sel_second_r, sel_second_nxt;
    logic [15:0]           sel_third_r, sel_third_nxt;
    logic [15:0]           inv_ctrl_r, inv_ctrl_nxt;
    bus_req_t              req_r, req_nxt;
    logic [31:0]           hrdata_r, hrdata_nxt;
    logic [2:0]            fit_sync_r;
    logic                  fit_r, fit_nxt;
    logic [`NUM_TERMS-1:0] term_r, term_nxt;
    logic [`NUM_TERMS-1:0] route_or;
    logic [`NUM_FLAGS-1:0] eff_flags;
    logic [`NUM_FLAGS*`DIGIT_W-1:0] digits;
    logic                  addr_phase;

    // the fitted pin is a board strap and may bounce while a module is seated
    // the mask is released after reset and applies only once the strap settles
    // three-stage pin synchroniser; only stages two and three are compared
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fit_sync_r <= 3'h0;
        else
            fit_sync_r <= {fit_sync_r[1:0], network_module_fitted};
    end

    // level changes only once the last two stages agree, filtering a glitch
    // a pulse shorter than two clocks never reaches the mask
    always_comb
    begin
        fit_nxt = fit_r;
        if (fit_sync_r[1] == fit_sync_r[2])
            fit_nxt = fit_sync_r[2];
    end

    // digits of unused third-register positions are not routed at all
    // digit placement
    // the third register only contributes its two low digits
    assign digits = {sel_third_r[7:0], sel_second_r, sel_first_r};

    // masking before routing keeps an invalid flag off every terminal at once
    // undetected flags dropped
    always_comb
    begin
        eff_flags = status_flags & flag_detected;
        if (fit_r)
            eff_flags[`SPEED_POSITIONING_COMPLETE_FLAG_IDX] = 1'b0;
    end

    // one OR tree per terminal; ten compares per terminal stay shallow
    // digit routes flag
    genvar t;
    generate
        for (t = 0; t < `NUM_TERMS; t++)
        begin : g_term
            always_comb
            begin
                route_or[t] = 1'b0;
                for (int f = 0; f < `NUM_FLAGS; f++)
                begin
                    // a digit above 3 never equals t+1, so it routes nowhere
                    if (digits[f*`DIGIT_W +: `DIGIT_W] == 4'(t + 1))
                        route_or[t] = route_or[t] | eff_flags[f];
                end
            end
        end
    endgenerate

    // inversion sits after the OR, so a reversed terminal idles high
    // per-terminal inversion
    // brake alone needs exclusive digit; software keeps that
    always_comb
    begin
        term_nxt = route_or ^ {inv_ctrl_r[8], inv_ctrl_r[4], inv_ctrl_r[0]};
    end

    // hsize is not checked: every register is a whole word, and narrower
    // writes simply update the low bits carried on hwdata
    // address phase is accepted whenever the bus is ready; slave has no waits
    assign addr_phase = hsel && hready && htrans[1];

    // only the low half of hwdata is stored; upper bits read back as zero
    // register writes land in the data phase following the address phase
    // software loads standard settings
    always_comb
    begin
        sel_first_nxt  = sel_first_r;
        sel_second_nxt = sel_second_r;
        sel_third_nxt  = sel_third_r;
        inv_ctrl_nxt   = inv_ctrl_r;
        req_nxt        = '0;
        hrdata_nxt     = 32'h0000_0000;
        if (req_r.valid && req_r.write)
        begin
            case (req_r.addr)
                `SEL_FIRST_OFS:  sel_first_nxt  = hwdata[15:0];
                `SEL_SECOND_OFS: sel_second_nxt = hwdata[15:0];
                `SEL_THIRD_OFS:  sel_third_nxt  = {8'h00, hwdata[7:0]};
                `INV_CTRL_OFS:   inv_ctrl_nxt   = {7'h00, hwdata[8], 3'h0, hwdata[4],
                                                   3'h0, hwdata[0]};
                default:         ;
            endcase
        end
        if (addr_phase)
        begin
            req_nxt.valid = 1'b1;
            req_nxt.write = hwrite;
            req_nxt.addr  = {haddr[11:2], 2'b00};
            // read data is prepared now so it stands through the data phase
            if (!hwrite)
            begin
                case ({haddr[11:2], 2'b00})
                    `SEL_FIRST_OFS:  hrdata_nxt = {16'h0000, sel_first_r};
                    `SEL_SECOND_OFS: hrdata_nxt = {16'h0000, sel_second_r};
                    `SEL_THIRD_OFS:  hrdata_nxt = {16'h0000, sel_third_r};
                    `INV_CTRL_OFS:   hrdata_nxt = {16'h0000, inv_ctrl_r};
                    `FLAG_STATE_OFS: hrdata_nxt = {21'h000000, fit_r, eff_flags};
                    `TERM_STATE_OFS: hrdata_nxt = {29'h00000000, term_r};
                    default:         hrdata_nxt = 32'h0000_0000;
                endcase
            end
        end
    end

    // outputs start low so the host sees every terminal inactive in reset
    // factory selection reset
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sel_first_r  <= `SEL_FIRST_RST;
            sel_second_r <= `SEL_SECOND_RST;
            sel_third_r  <= `SEL_THIRD_RST;
            inv_ctrl_r   <= `INV_CTRL_RST;
            req_r        <= '0;
            hrdata_r     <= 32'h0000_0000;
            fit_r        <= 1'b0;
            term_r       <= 3'h0;
        end
        else
        begin
            sel_first_r  <= sel_first_nxt;
            sel_second_r <= sel_second_nxt;
            sel_third_r  <= sel_third_nxt;
            inv_ctrl_r   <= inv_ctrl_nxt;
            req_r        <= req_nxt;
            hrdata_r     <= hrdata_nxt;
            fit_r        <= fit_nxt;
            term_r       <= term_nxt;
        end
    end

    // a slave with no wait states keeps the bus simple; read data is taken in
    // the address phase, so a read right after a write to the same register
    // returns the old contents
    // outputs straight from flops; zero wait states and always OKAY
    assign hrdata             = hrdata_r;
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign out_terminal_one   = term_r[0];
    assign out_terminal_two   = term_r[1];
    assign out_terminal_three = term_r[2];

    // terminal checks below sample the registered terminals; inversion is folded into each
    // expectation or excluded in its antecedent, so software may reverse any terminal at any time
    // positioning flag on its terminal
    chk_positioning_complete_flag_route: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel_first_r[3:0] == 4'h1 && eff_flags[0]) |=> out_terminal_one != $past(inv_ctrl_r[0]))
        else $error("positioning flag not on terminal one");

    // active brake flag routed by digit 2 forces terminal two
    chk_or_merge: assert property (@(posedge hclk) disable iff (!hresetn)
        (inv_ctrl_r[4] == 1'b0 && sel_second_r[11:8] == 4'h2 && eff_flags[6])
        |=> out_terminal_two)
        else $error("brake flag not ORed onto terminal two");

    chk_undetected: assert property (@(posedge hclk) disable iff (!hresetn)
        !flag_detected[0] |-> !eff_flags[0])
        else $error("undetected flag passed through");

    chk_speed_mask: assert property (@(posedge hclk) disable iff (!hresetn)
        fit_r |-> !eff_flags[1])
        else $error("speed coincidence not masked");

    chk_invert_three: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> out_terminal_three == ($past(route_or[2]) ^ $past(inv_ctrl_r[8])))
        else $error("terminal three inversion wrong");

    chk_factory_sel: assert property (@(posedge hclk)
        $rose(hresetn) |-> sel_first_r == 16'h3211 && sel_second_r == 16'h0000)
        else $error("selection reset value wrong");

    chk_invert_rst: assert property (@(posedge hclk)
        $rose(hresetn) |-> inv_ctrl_r == 16'h0000)
        else $error("inversion reset value wrong");

    chk_undef_digit: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel_first_r[3:0] > 4'h3 && eff_flags[9:1] == 9'h000)
        |-> route_or == 3'h0)
        else $error("undefined digit routed a flag");

    chk_index_place: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel_third_r[7:4] == 4'h3 && eff_flags[9] && !inv_ctrl_r[8])
        |=> out_terminal_three)
        else $error("index phase digit misplaced");

    chk_invert_one: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> out_terminal_one == ($past(route_or[0]) ^ $past(inv_ctrl_r[0])))
        else $error("terminal one inversion wrong");

    chk_invert_two: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> out_terminal_two == ($past(route_or[1]) ^ $past(inv_ctrl_r[4])))
        else $error("terminal two inversion wrong");

    // digit three and spare bits never stored
    chk_invert_spare: assert property (@(posedge hclk) disable iff (!hresetn)
        (inv_ctrl_r & 16'hfeee) == 16'h0000)
        else $error("unused inversion bits stored");

    // third select keeps only two digits
    chk_third_spare: assert property (@(posedge hclk) disable iff (!hresetn)
        sel_third_r[15:8] == 8'h00)
        else $error("unused third select digits stored");

    // mask follows only a settled pin
    chk_fit_settled: assert property (@(posedge hclk) disable iff (!hresetn)
        $changed(fit_r) |-> fit_r == $past(fit_sync_r[1]) && fit_r == $past(fit_sync_r[2]))
        else $error("fitted level taken before stages agreed");

    chk_or_shared: assert property (@(posedge hclk) disable iff (!hresetn)
        (sel_first_r[7:0] == 8'h11 && (eff_flags[0] || eff_flags[1]) && !inv_ctrl_r[0])
        |=> out_terminal_one)
        else $error("shared terminal one not ORed");

    // every terminal low right after reset
    chk_term_rst: assert property (@(posedge hclk)
        $rose(hresetn) |-> term_r == 3'h0)
        else $error("terminal active right after reset");

endmodule

`default_nettype wire

// File: sim/host_seq_inputs.sv
// host sequence input model: latches the three output terminals
// assumes terminals are registered in the hclk domain
`timescale 1ns/1ps
`default_nettype none
module host_seq_inputs
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic [2:0] terms,
    output logic      [2:0] seen
);
    // one latch stage; a debounce filter would only add delay
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            seen <= 3'h0;
        else
            seen <= terms;
    end
endmodule
`default_nettype wire

// File: sim/test_status_output_router.sv
// bench for the status output router: ahb-lite master, routing checks
// assumes the host model latches terminals one clock late
`timescale 1ns/1ps
`include "status_output_router_defines.svh"
`default_nettype none
module test_status_output_router;
    import status_output_router_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hready, hresp, fit;
    logic [1:0]  htrans;
    logic [2:0]  hsize, seen;
    logic [31:0] haddr, hwdata, hrdata;
    logic [9:0]  flg, det;
    logic [15:0] s1, s2, s3, inv;
    logic        t1, t2, t3;
    int          mismatches, checks;

    status_output_router i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .status_flags(flg), .flag_detected(det),
        .network_module_fitted(fit), .out_terminal_one(t1),
        .out_terminal_two(t2), .out_terminal_three(t3));
    host_seq_inputs i_host (.hclk(hclk), .hresetn(hresetn), .terms({t3, t2, t1}),
        .seen(seen));

    task automatic cmp(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("[ERR] %0t seen %h exp %h", $time, s, e);
        end
    endtask
    // one single transfer; held until hready is seen high
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        haddr  <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        r = hrdata;
    endtask
    // shadow copy keeps the masks the register map applies
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
        if (a[11:0] == `SEL_FIRST_OFS) s1 = d[15:0];
        if (a[11:0] == `SEL_SECOND_OFS) s2 = d[15:0];
        if (a[11:0] == `SEL_THIRD_OFS) s3 = {8'h0, d[7:0]};
        if (a[11:0] == `INV_CTRL_OFS) inv = d[15:0] & 16'h0111;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        cmp(r, e);
        cmp({31'h0, hresp}, 32'h0);
    endtask
    // settle, then compare against routing worked out from the shadows
    task automatic chk_t();
        logic [39:0] sel;
        logic [3:0]  g;
        logic [2:0]  t;
        sel = {s3[7:0], s2, s1};
        t   = 3'h0;
        // the fitted pin needs three sync stages plus mask, terminal and host flops
        repeat (8) @(posedge hclk);
        for (int i = 0; i < 10; i++)
        begin
            g = sel[4*i +: 4];
            if (flg[i] && det[i] && !(i == 1 && fit) && g != 4'h0 && g < 4'h4)
                t[g-1] = 1'b1;
        end
        cmp({29'h0, seen}, {29'h0, t ^ {inv[8], inv[4], inv[0]}});
    endtask
    task automatic t_regs();
        rd({20'h0, `SEL_FIRST_OFS}, 32'h3211);
        rd({20'h0, `SEL_SECOND_OFS}, 32'h0);
        rd({20'h0, `SEL_THIRD_OFS}, 32'h0);
        rd({20'h0, `INV_CTRL_OFS}, 32'h0);
        wr(32'h20, 32'hffff_ffff);
        rd(32'h20, 32'h0);
        rd({20'h0, `SEL_FIRST_OFS}, 32'h3211);
    endtask
    task automatic t_fact();
        for (int i = 0; i < 10; i++)
        begin
            flg <= 10'h1 << i;
            chk_t();
        end
        flg <= 10'h3ff;
        chk_t();
    endtask
    // every digit value on flag 0, flag 1 fixed on terminal one
    task automatic t_codes();
        for (int v = 0; v < 16; v++)
        begin
            wr({20'h0, `SEL_FIRST_OFS}, 32'h10 | v);
            flg <= 10'h001;
            chk_t();
            flg <= 10'h003;
            chk_t();
        end
    endtask
    task automatic t_std();
        wr({20'h0, `SEL_FIRST_OFS}, 32'h3001);
        wr({20'h0, `SEL_SECOND_OFS}, 32'h0200);
        wr({20'h0, `SEL_THIRD_OFS}, 32'h1331);
        rd({20'h0, `SEL_THIRD_OFS}, 32'h31);
        flg <= 10'h200;
        chk_t();
        wr({20'h0, `SEL_THIRD_OFS}, 32'h0);
        flg <= 10'h040;
        chk_t();
        flg <= 10'h3ff;
        chk_t();
    endtask
    // digit three set as well; it must stay without effect
    task automatic t_inv();
        for (int v = 0; v < 8; v++)
        begin
            wr({20'h0, `INV_CTRL_OFS}, {v[2], 3'h0, v[1], 3'h0, v[0]} | 32'h1000);
            rd({20'h0, `INV_CTRL_OFS}, {v[2], 3'h0, v[1], 3'h0, v[0]});
            flg <= 10'h0;
            chk_t();
        end
    endtask
    task automatic t_mask();
        flg <= 10'h3ff;
        for (int i = 0; i < 10; i++)
        begin
            det <= ~(10'h1 << i);
            chk_t();
        end
        det <= 10'h3ff;
        wr({20'h0, `SEL_FIRST_OFS}, 32'h0020);
        flg <= 10'h002;
        fit <= 1'b1;
        chk_t();
        rd({20'h0, `FLAG_STATE_OFS}, 32'h400);
        rd({20'h0, `TERM_STATE_OFS}, 32'h7);
        fit <= 1'b0;
        chk_t();
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // clock at 100 MHz
    initial
    begin
        hclk = 1'b0;
        forever
            #5 hclk = ~hclk;
    end
    // hang guard, well beyond the roughly 630 cycles needed
    initial
    begin
        #400000;
        mismatches++;
        complete_run();
    end
    initial
    begin
        {hresetn, hwrite, htrans, haddr, hwdata, flg, fit} = '0;
        hsel = 1'b1;
        hsize = 3'h2;
        det = 10'h3ff;
        {s1, s2, s3, inv} = {16'h3211, 48'h0};
        mismatches = 0;
        checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_fact();
        t_codes();
        t_std();
        t_inv();
        t_mask();
        complete_run();
    end
endmodule
`default_nettype wire
